//--- hw/urx_pkg.sv
// Package for the serial receiver error, interrupt and wake-up block.
// Assumes a single 50 MHz clock and an APB register bus with 32-bit data.
package urx_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STAT_OFF = 8'h04;
	localparam logic [7:0] DATA_OFF = 8'h08;
	localparam logic [7:0] CNT_OFF  = 8'h0c;
	localparam logic [7:0] BAUD_OFF = 8'h10;

	// ----------------------------------------
	// Reset values and timing counts
	// ----------------------------------------
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [15:0] BAUD_RST    = 16'h001a;
	localparam int          FIFO_DEPTH  = 4;
	localparam int          CLK_MHZ     = 50;
	localparam int          SETTLE_NS   = 1000;
	localparam int          SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  SAMP_FIRST  = 4'h7;
	localparam logic [3:0]  SAMP_LAST   = 4'h9;
	localparam logic [3:0]  OVS_LAST    = 4'hf;

	// ----------------------------------------
	// Control register layout, bit 15 down to 0
	// ----------------------------------------
	typedef struct packed {
		logic       wake_enable;
		logic       global_int_enable;
		logic       serial_int_enable;
		logic       tx_idle_int_enable;
		logic       tx_empty_int_enable;
		logic [1:0] trig_level;
		logic       two_stop;
		logic [1:0] parity_type;
		logic       parity_enable;
		logic       nine_bit_select;
		logic       addr_detect_enable;
		logic       rx_int_enable;
		logic       rx_enable;
		logic       serial_unit_enable;
	} urx_ctrl_t;

	// Status register layout, bit 7 down to 0
	typedef struct packed {
		logic tx_idle;
		logic tx_empty;
		logic rx_idle;
		logic rx_avail_flag;
		logic overrun_flag;
		logic noise_flag;
		logic framing_flag;
		logic parity_err_flag;
	} urx_stat_t;

	// One buffered byte with its own error marks
	typedef struct packed {
		logic       parity_err;
		logic       framing;
		logic       noise;
		logic [8:0] data;
	} urx_ent_t;

	localparam logic [1:0] PAR_EVEN  = 2'h0;
	localparam logic [1:0] PAR_ODD   = 2'h1;
	localparam logic [1:0] PAR_MARK  = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP1, ST_STOP2} urx_st_t;
endpackage

//--- hw/urx_mem.sv
// Small register-file memory for the receive buffer.
// Assumes one clock; read data is registered, one cycle behind raddr.
`timescale 1ns/1ps
`default_nettype none
module urx_mem #(
	parameter int W  = 12,
	parameter int D  = 4,
	parameter int AW = 2
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// Write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read side
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_q
);
	logic [W-1:0] mem [D];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

//--- hw/urx_core.sv
// Serial receiver with error flags, four-byte buffer, interrupt pulse and pin wake-up.
// Assumes an APB master on ref_clk, transmitter status levels on the same clock,
// and an asynchronous receive pin.
`timescale 1ns/1ps
`default_nettype none
module urx_core #(
	parameter int DEPTH  = urx_pkg::FIFO_DEPTH,
	parameter int SETTLE = urx_pkg::SETTLE_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial pin and clock state
	input  wire logic        rx_pin,
	input  wire logic        uart_clk_off,
	// Transmitter status levels
	input  wire logic        tx_empty,
	input  wire logic        tx_idle,
	// Interrupt and wake
	output logic             irq_n,
	output logic             wake_evt
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two, at least 2");
	end
	if (SETTLE < 1 || SETTLE > 65535) begin : g_bad_settle
		$error("SETTLE must be 1 to 65535");
	end

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	urx_pkg::urx_ctrl_t ctrl_q;
	logic [15:0]        baud_q;
	logic               s1_q, s2_q, s3_q, rx_lvl_q, rx_prev_q;
	logic               fall;
	logic [15:0]        div_q;
	logic               tick;
	logic               run;
	urx_pkg::urx_st_t   st_q;
	logic [3:0]         scnt_q;
	logic [2:0]         samp_q;
	logic [3:0]         bitn_q;
	logic [8:0]         sh_q;
	logic               nf_q, pe_q, fe_q;
	logic               bit_end, bit_val, bit_noisy;
	logic [8:0]         data9;
	logic               par_exp;
	logic               done_q;
	urx_pkg::urx_ent_t  new_q, hold_q;
	logic               hold_v_q;
	logic [CW-1:0]      cnt_q;
	logic [AW-1:0]      wp_q, rp_q;
	logic               full, push, pop;
	urx_pkg::urx_ent_t  push_ent, head;
	logic               ov_q, arm_q;
	logic               apb_done, rd_stat, rd_data, wr_ctrl, wr_baud;
	logic               tx_empty_q, tx_idle_q;
	logic               ev_rx, ev_ov, ev_tx, ev_wake, ev_any, pend_q;
	logic               wake_seen_q;
	logic [15:0]        settle_q;
	logic               settling;
	logic               fire;
	urx_pkg::urx_stat_t stat;
	logic [31:0]        rd_mux;
	logic               hit;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	// One wait state: pready rises in the second access cycle, so read data is a flop
	assign apb_done = psel & penable & pready;
	assign rd_stat  = apb_done & ~pwrite & (paddr == urx_pkg::STAT_OFF);
	assign rd_data  = apb_done & ~pwrite & (paddr == urx_pkg::DATA_OFF);
	assign wr_ctrl  = apb_done & pwrite & (paddr == urx_pkg::CTRL_OFF);
	assign wr_baud  = apb_done & pwrite & (paddr == urx_pkg::BAUD_OFF);

	always_comb begin
		hit    = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			urx_pkg::CTRL_OFF: rd_mux = {16'h0000, ctrl_q};
			urx_pkg::STAT_OFF: rd_mux = {24'h00_0000, stat};
			urx_pkg::DATA_OFF: rd_mux = {23'h00_0000, head.data};
			urx_pkg::CNT_OFF:  rd_mux = {{(32-CW){1'b0}}, cnt_q};
			urx_pkg::BAUD_OFF: rd_mux = {16'h0000, baud_q};
			default:           hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~hit;
			prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Writes to data and count are dropped; a status write only arms the overrun clear; flags stay read-only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= urx_pkg::CTRL_RST;
			baud_q <= urx_pkg::BAUD_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= pwdata[15:0];
			end
			if (wr_baud) begin
				baud_q <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Pin synchroniser and filter
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q      <= 1'b1;
			s2_q      <= 1'b1;
			s3_q      <= 1'b1;
			rx_lvl_q  <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			s1_q      <= rx_pin;
			s2_q      <= s1_q;
			s3_q      <= s2_q;
			rx_prev_q <= rx_lvl_q;
			if (s2_q == s3_q) begin
				rx_lvl_q <= s3_q;
			end
		end
	end
	assign fall = rx_prev_q & ~rx_lvl_q;

	// ----------------------------------------
	// Oversampling receiver
	// ----------------------------------------
	// Clock off freezes divider and state in place, so a frame resumes where it stopped
	assign run  = ~uart_clk_off;
	assign tick = run & (div_q >= baud_q);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 16'h0000;
		end else if (run) begin
			div_q <= tick ? 16'h0000 : div_q + 16'h0001;
		end
	end

	assign bit_end   = tick & (scnt_q == urx_pkg::OVS_LAST);
	assign bit_val   = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) | (samp_q[0] & samp_q[2]);
	assign bit_noisy = ~(&samp_q) & (|samp_q);
	assign data9     = ctrl_q.nine_bit_select ? sh_q : {1'b0, sh_q[8:1]};

	always_comb begin
		case (ctrl_q.parity_type)
			urx_pkg::PAR_EVEN: par_exp = ^data9;
			urx_pkg::PAR_ODD:  par_exp = ~^data9;
			urx_pkg::PAR_MARK: par_exp = 1'b1;
			default:           par_exp = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= urx_pkg::ST_IDLE;
			scnt_q <= 4'h0;
			samp_q <= 3'h7;
			bitn_q <= 4'h0;
			sh_q   <= 9'h000;
			nf_q   <= 1'b0;
			pe_q   <= 1'b0;
			fe_q   <= 1'b0;
			done_q <= 1'b0;
			new_q  <= '0;
		end else if (!ctrl_q.serial_unit_enable || !ctrl_q.rx_enable || (settling && run)) begin
			st_q   <= urx_pkg::ST_IDLE;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tick && st_q != urx_pkg::ST_IDLE) begin
				scnt_q <= scnt_q + 4'h1;
				if (scnt_q >= urx_pkg::SAMP_FIRST && scnt_q <= urx_pkg::SAMP_LAST) begin
					samp_q <= {rx_lvl_q, samp_q[2:1]};
				end
			end
			if (bit_end && bit_noisy) begin
				nf_q <= 1'b1;
			end
			case (st_q)
				urx_pkg::ST_IDLE: begin
					if (run && fall) begin
						st_q   <= urx_pkg::ST_START;
						scnt_q <= 4'h0;
						nf_q   <= 1'b0;
						pe_q   <= 1'b0;
						fe_q   <= 1'b0;
					end
				end
				urx_pkg::ST_START: begin
					if (bit_end) begin
						st_q   <= bit_val ? urx_pkg::ST_IDLE : urx_pkg::ST_DATA;
						bitn_q <= 4'h0;
					end
				end
				urx_pkg::ST_DATA: begin
					if (bit_end) begin
						sh_q   <= {bit_val, sh_q[8:1]};
						bitn_q <= bitn_q + 4'h1;
						if (bitn_q == (ctrl_q.nine_bit_select ? 4'h8 : 4'h7)) begin
							st_q <= ctrl_q.parity_enable ? urx_pkg::ST_PAR : urx_pkg::ST_STOP1;
						end
					end
				end
				urx_pkg::ST_PAR: begin
					if (bit_end) begin
						pe_q <= (bit_val != par_exp);
						st_q <= urx_pkg::ST_STOP1;
					end
				end
				urx_pkg::ST_STOP1: begin
					if (bit_end) begin
						fe_q <= ~bit_val;
						if (ctrl_q.two_stop) begin
							st_q <= urx_pkg::ST_STOP2;
						end else begin
							st_q   <= urx_pkg::ST_IDLE;
							done_q <= 1'b1;
							new_q  <= '{parity_err: pe_q, framing: ~bit_val, noise: nf_q | bit_noisy, data: data9};
						end
					end
				end
				urx_pkg::ST_STOP2: begin
					if (bit_end) begin
						st_q   <= urx_pkg::ST_IDLE;
						done_q <= 1'b1;
						new_q  <= '{parity_err: pe_q, framing: fe_q | ~bit_val, noise: nf_q | bit_noisy,
							data: data9};
					end
				end
				default: st_q <= urx_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Receive buffer and holding stage
	// ----------------------------------------
	// The holding stage stands in for the shift register: a fifth byte waits here
	assign full     = (cnt_q == CW'(DEPTH));
	assign push     = ~full & (done_q | hold_v_q);
	assign push_ent = hold_v_q ? hold_q : new_q;
	assign pop      = rd_data & (cnt_q != '0);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_v_q <= 1'b0;
			hold_q   <= '0;
		end else if (!ctrl_q.rx_enable) begin
			hold_v_q <= 1'b0;
		end else if (done_q && (full || hold_v_q)) begin
			hold_v_q <= 1'b1;
			hold_q   <= new_q;
		end else if (push) begin
			hold_v_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			wp_q  <= '0;
			rp_q  <= '0;
		end else begin
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
			if (push) begin
				wp_q <= wp_q + AW'(1);
			end
			if (pop) begin
				rp_q <= rp_q + AW'(1);
			end
		end
	end

	// Entry carries its own error marks so each flag stays with its byte
	urx_mem #(
		.W  ($bits(urx_pkg::urx_ent_t)),
		.D  (DEPTH),
		.AW (AW)
	) u_mem (
		.clk     (ref_clk),
		.rst_n   (rst_n),
		.we      (push),
		.waddr   (wp_q),
		.wdata   (push_ent),
		.raddr   (rp_q),
		.rdata_q (head)
	);

	// ----------------------------------------
	// Overrun flag and clear sequence
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_q  <= 1'b0;
			arm_q <= 1'b0;
		end else begin
			if (apb_done && paddr == urx_pkg::STAT_OFF) begin
				arm_q <= 1'b1;
			end else if (rd_data) begin
				arm_q <= 1'b0;
			end
			if (done_q && full) begin
				ov_q <= 1'b1;
			end else if (rd_data && arm_q) begin
				ov_q <= 1'b0;
			end
		end
	end

	// Noise, framing and parity flags show the head byte, so any pop brings up the next byte's marks
	always_comb begin
		stat                 = '0;
		stat.tx_idle         = tx_idle;
		stat.tx_empty        = tx_empty;
		stat.rx_idle         = (st_q == urx_pkg::ST_IDLE);
		stat.rx_avail_flag   = (cnt_q != '0);
		stat.overrun_flag    = ov_q;
		stat.noise_flag      = stat.rx_avail_flag & head.noise;
		stat.framing_flag    = stat.rx_avail_flag & head.framing;
		stat.parity_err_flag = stat.rx_avail_flag & head.parity_err & ctrl_q.parity_enable;
	end

	// ----------------------------------------
	// Interrupt events
	// ----------------------------------------
	assign ev_tx = (tx_empty & ~tx_empty_q & ctrl_q.tx_empty_int_enable) |
		(tx_idle & ~tx_idle_q & ctrl_q.tx_idle_int_enable);
	assign ev_rx = push & ctrl_q.rx_int_enable & (cnt_q >= {{(CW-2){1'b0}}, ctrl_q.trig_level}) &
		(~ctrl_q.addr_detect_enable |
		(ctrl_q.nine_bit_select ? push_ent.data[8] : push_ent.data[7]));
	assign ev_ov   = done_q & full & ctrl_q.rx_int_enable;
	assign ev_wake = uart_clk_off & fall & ctrl_q.wake_enable & ctrl_q.serial_unit_enable &
		ctrl_q.rx_enable & ctrl_q.rx_int_enable;
	assign ev_any  = (ev_tx | ev_rx | ev_ov | ev_wake) &
		ctrl_q.global_int_enable & ctrl_q.serial_int_enable;
	assign settling = wake_seen_q | (settle_q != 16'h0000);
	assign fire     = pend_q & irq_n & ~settling & ~uart_clk_off;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_empty_q <= 1'b0;
			tx_idle_q  <= 1'b0;
		end else begin
			tx_empty_q <= tx_empty;
			tx_idle_q  <= tx_idle;
		end
	end

	// Settling starts once the clock returns after a wake; pin data is ignored until done
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_seen_q <= 1'b0;
			settle_q    <= 16'h0000;
			wake_evt    <= 1'b0;
		end else begin
			wake_evt <= ev_wake;
			if (ev_wake) begin
				wake_seen_q <= 1'b1;
			end else if (wake_seen_q && !uart_clk_off) begin
				wake_seen_q <= 1'b0;
				settle_q    <= 16'(SETTLE);
			end else if (settle_q != 16'h0000) begin
				settle_q <= settle_q - 16'h0001;
			end
		end
	end

	// A new event in the firing cycle is kept pending, never lost
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			irq_n  <= 1'b1;
		end else begin
			pend_q <= ev_any | (pend_q & ~fire);
			irq_n  <= ~fire;
		end
	end
endmodule
`default_nettype wire

//--- tb/urx_props.sv
// Port checker for urx_core: bus answer, interrupt pulse and wake timing.
// Assumes it is bound onto urx_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module urx_props (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins and events
	input wire logic        uart_clk_off,
	input wire logic        irq_n,
	input wire logic        wake_evt
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------
	// Register bus
	// ------------------------------------------
	a_ready_after_access: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle into access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_ready_needs_access: assert property (!(psel && penable) |=> !pready)
		else $error("answer without access");
	a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without answer or with data");
	// ------------------------------------------
	// Interrupt and wake
	// ------------------------------------------
	a_irq_one_cycle: assert property (!irq_n |=> irq_n)
		else $error("interrupt pulse too long");
	a_irq_held_off: assert property ($past(uart_clk_off) |-> irq_n)
		else $error("interrupt while clock off");
	a_wake_single: assert property (wake_evt |=> !wake_evt)
		else $error("wake pulse too long");
	a_wake_clk_off: assert property (wake_evt |-> $past(uart_clk_off))
		else $error("wake with clock running");
	c_err: cover property (pslverr);
	c_irq: cover property (!irq_n);
	c_wake: cover property (wake_evt);
endmodule
bind urx_core urx_props u_urx_props (.ref_clk, .rst_n, .psel, .penable, .prdata, .pready, .pslverr,
	.uart_clk_off, .irq_n, .wake_evt);
`default_nettype wire

//--- tb/urx_tx_model.sv
// Remote serial transmitter model driving the receive pin.
// Assumes the pin idles high through a pull-up; bits change after ref_clk edges.
`timescale 1ns/1ps
`default_nettype none
module urx_tx_model #(
	parameter int BT = 32
) (
	// Clock
	input  wire logic ref_clk,
	// Serial line
	output var  logic rx_pin
);
	initial rx_pin = 1'b1;
	// Frame LSB first; pb below zero means no parity; g flips bit g briefly mid-bit
	task automatic send(input logic [8:0] d, input int nd, input int pb, input logic [1:0] st,
		input int ns, input int g);
		logic [13:0] f;
		int          n;
		f = 14'h3fff;
		f[0] = 1'b0;
		for (int i = 0; i < nd; i++) f[i+1] = d[i];
		n = nd + 1;
		if (pb >= 0) begin
			f[n] = pb[0];
			n++;
		end
		for (int i = 0; i < ns; i++) f[n+i] = st[i];
		n = n + ns;
		for (int i = 0; i < n; i++) begin
			for (int c = 0; c < BT; c++) begin
				@(posedge ref_clk);
				rx_pin <= (i == g && c >= BT/2 && c < BT/2 + 2) ? ~f[i] : f[i];
			end
		end
		// One idle bit so the next start edge is always seen
		@(posedge ref_clk);
		rx_pin <= 1'b1;
		repeat (BT) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

//--- tb/urx_core_tb_top.sv
// Testbench for urx_core: bus tasks, one task per scenario, closing report.
// Assumes urx_tx_model drives the pin and urx_props is bound to the core.
`timescale 1ns/1ps
`default_nettype none
module urx_core_tb_top;
	localparam int          BT   = 32;
	localparam logic [31:0] BASE = 32'h0000_6007;
	logic        ref_clk  = 1'b0;
	logic        rst_n    = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic        clk_off  = 1'b0;
	logic        tx_empty = 1'b0;
	logic        tx_idle  = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx_pin;
	logic        irq_n;
	logic        wake_evt;
	logic [31:0] r;
	logic        e;
	int          error_cnt = 0;
	int          compares  = 0;
	int          irqs      = 0;
	int          wakes     = 0;

	urx_core #(.DEPTH(4), .SETTLE(4)) u_urx_core (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rx_pin, .uart_clk_off(clk_off), .tx_empty, .tx_idle,
		.irq_n, .wake_evt);
	urx_tx_model #(.BT(BT)) u_urx_tx_model (.ref_clk, .rx_pin);

	always #10 ref_clk = ~ref_clk;
	// Counted mid-cycle so a task resuming at the next rising edge already sees the count
	always @(negedge ref_clk) begin
		if (irq_n === 1'b0) irqs++;
		if (wake_evt === 1'b1) wakes++;
	end
	// ------------------------------------------
	// Shared tasks
	// ------------------------------------------
	task automatic test_done;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bad(input logic c);
		if (c) begin
			error_cnt++;
			$display("ERROR %0t wait ran out", $time);
			test_done();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Request stands until the rising edge at which pready is seen high
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		bad(pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask
	task automatic waitn(input logic [31:0] x);
		int n;
		n = 0;
		do begin
			apb(1'b0, urx_pkg::CNT_OFF, 32'h0);
			n++;
		end while (r !== x && n < 40);
		bad(r !== x);
	endtask
	task automatic reset_dut;
		rst_n <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic cfg(input logic [31:0] c);
		reset_dut();
		apb(1'b1, urx_pkg::BAUD_OFF, 32'h1);
		apb(1'b1, urx_pkg::CTRL_OFF, c);
	endtask
	task automatic tx8(input logic [7:0] d);
		u_urx_tx_model.send({1'b0, d}, 8, -1, 2'b11, 1, -1);
	endtask
	// ------------------------------------------
	// Scenarios
	// ------------------------------------------
	task automatic s_regs;
		cfg(BASE);
		rc(urx_pkg::STAT_OFF, 32'h1f, 32'h0);
		apb(1'b1, urx_pkg::STAT_OFF, 32'hff);
		rc(urx_pkg::STAT_OFF, 32'h1f, 32'h0);
		rc(8'h14, 32'hffff_ffff, 32'h0);
		chk({31'h0, e}, 32'h1);
		rc(urx_pkg::CNT_OFF, 32'hffff_ffff, 32'h0);
	endtask
	task automatic s_trig;
		int i0;
		cfg(BASE | 32'h200);
		i0 = irqs;
		tx8(8'ha5);
		waitn(1);
		chk(irqs - i0, 0);
		tx8(8'h5a);
		waitn(2);
		chk(irqs - i0, 1);
		rc(urx_pkg::STAT_OFF, 32'h17, 32'h10);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'ha5);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h5a);
		rc(urx_pkg::STAT_OFF, 32'h10, 32'h0);
	endtask
	task automatic s_ovr;
		cfg(BASE);
		for (int i = 0; i < 5; i++) tx8(8'h30 + 8'(i));
		waitn(4);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h30);
		rc(urx_pkg::STAT_OFF, 32'h8, 32'h8);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h31);
		rc(urx_pkg::STAT_OFF, 32'h8, 32'h0);
		for (int i = 2; i < 5; i++) rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h30 + i);
	endtask
	task automatic s_noise;
		cfg(BASE);
		u_urx_tx_model.send(9'h03c, 8, -1, 2'b11, 1, 3);
		waitn(1);
		rc(urx_pkg::STAT_OFF, 32'h14, 32'h14);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h3c);
		rc(urx_pkg::STAT_OFF, 32'h4, 32'h0);
	endtask
	task automatic s_frame;
		cfg(BASE | 32'h100);
		u_urx_tx_model.send(9'h05a, 8, -1, 2'b01, 2, -1);
		u_urx_tx_model.send(9'h0c3, 8, -1, 2'b11, 2, -1);
		waitn(2);
		rc(urx_pkg::STAT_OFF, 32'h2, 32'h2);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h5a);
		rc(urx_pkg::STAT_OFF, 32'h2, 32'h0);
		rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'hc3);
	endtask
	task automatic s_par;
		logic c;
		for (int p = 0; p < 4; p++) begin
			cfg(BASE | 32'h20 | (p << 6));
			c = p[1] ? ~p[0] : (^8'h6b ^ p[0]);
			u_urx_tx_model.send(9'h06b, 8, c ? 0 : 1, 2'b11, 1, -1);
			u_urx_tx_model.send(9'h06b, 8, c ? 1 : 0, 2'b11, 1, -1);
			waitn(2);
			rc(urx_pkg::STAT_OFF, 32'h1, 32'h1);
			rc(urx_pkg::DATA_OFF, 32'hffff_ffff, 32'h6b);
			rc(urx_pkg::STAT_OFF, 32'h1, 32'h0);
		end
	endtask
	task automatic s_addr;
		logic [15:0] cf [6] = '{16'h8, 16'h8, 16'h18, 16'h18, 16'h0, 16'h0};
		logic [8:0]  dd [6] = '{9'h005, 9'h085, 9'h0ff, 9'h100, 9'h005, 9'h085};
		int          ex [6] = '{0, 1, 0, 1, 1, 1};
		int          i0;
		for (int k = 0; k < 6; k++) begin
			cfg(BASE | cf[k]);
			i0 = irqs;
			u_urx_tx_model.send(dd[k], cf[k][4] ? 9 : 8, -1, 2'b11, 1, -1);
			waitn(1);
			chk(irqs - i0, ex[k]);
		end
	endtask
	task automatic s_txint;
		int i0;
		cfg(32'h6800);
		i0 = irqs;
		tx_empty <= 1'b1;
		tx_idle <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(irqs - i0, 1);
		apb(1'b1, urx_pkg::CTRL_OFF, 32'h7000);
		tx_idle <= 1'b0;
		@(posedge ref_clk);
		tx_idle <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(irqs - i0, 2);
		tx_empty <= 1'b0;
		tx_idle <= 1'b0;
	endtask
	task automatic s_wake(input logic [31:0] c, input int x);
		int i0;
		int w0;
		int n;
		cfg(c);
		i0 = irqs;
		w0 = wakes;
		n = 0;
		clk_off <= 1'b1;
		tx8(8'h00);
		chk(wakes - w0, 1);
		chk(irqs - i0, 0);
		clk_off <= 1'b0;
		while (irqs == i0 && n < 30) begin
			@(posedge ref_clk);
			n++;
		end
		chk(irqs - i0, x);
		if (x == 1) chk({31'h0, n >= 4}, 32'h1);
		rc(urx_pkg::CNT_OFF, 32'hffff_ffff, 32'h0);
		rc(urx_pkg::CTRL_OFF, 32'hffff, c);
	endtask

	initial begin
		s_regs();
		s_trig();
		s_ovr();
		s_noise();
		s_frame();
		s_par();
		s_addr();
		s_txint();
		s_wake(BASE | 32'h8000, 1);
		s_wake(32'ha007, 0);
		test_done();
	end
endmodule
`default_nettype wire
